// [inc/stx_regs.vh]
/*
 constants for the serial transmitter: buffer size, bit clock
 dividers, frame field codes and reset values.
 assumes inclusion by bare name from the design file.
*/
`ifndef STX_REGS_VH
`define STX_REGS_VH

// transmit buffer shape
`define STX_FIFO_W      9
`define STX_FIFO_DEPTH  8
`define STX_FIFO_AW     3

// bit clock divide, minus one: normal, double speed, synchronous
`define STX_DIV_NORM    4'hf
`define STX_DIV_DBL     4'h7
`define STX_DIV_SYNC    4'h1

// character size code for nine data bits
`define STX_SIZE_NINE   3'h7

// parity mode field positions
`define STX_PAR_EN_BIT  1
`define STX_PAR_ODD_BIT 0

// reset values
`define STX_LINE_IDLE   1'b1
`define STX_BAUD_RST    12'h000

`endif

// [rtl/stx_top.v]
/*
 serial transmitter with parity: transmit buffer fifo and the
 frame shifter with flags and interrupt requests.
 assumes all inputs synchronous to CLK and that software keeps
 the frame format and baud setting steady while a frame runs.
*/
// What this block does
// - even parity is xor of data bits, odd parity is its inverse
// - parity bit goes after last data bit, before first stop bit
// - while transmitter_on is set the block drives serial_out_pin
// - synchronous slave mode clocks bits from the sync_clock_pin
// - writing data_buffer_port loads the buffer and starts sending
// - buffer moves to shifter when idle or right after last stop
// - shifter sends a whole frame at the selected bit rate
// - short characters send only the configured low bits
// - tx_buffer_empty_flag is high exactly while the buffer is empty
// - buffer-empty request holds while flag and enable are set
// - writing data_buffer_port clears tx_buffer_empty_flag
// - tx_complete_flag sets when frame ends and buffer is empty
// - tx_complete_flag clears on service or on a written one
// - complete request follows the flag when its enable is set
// - clearing transmitter_on waits until shifter and buffer empty
// - low start, data lsb first, one or two high stops, idle high
// - parity is sent only when parity_enable_bit is one
// - outside sync slave mode, bit clock is baud tick divided by 2, 8 or 16 by mode
`timescale 1ns/1ns
`include "stx_regs.vh"

// simple synchronous fifo, one entry per valid/ready beat
module stx_fifo #(
   parameter W  = `STX_FIFO_W,
   parameter D  = `STX_FIFO_DEPTH,
   parameter AW = `STX_FIFO_AW
) (
   // clock and reset
   input  wire         clk,
   input  wire         srst,
   // fill side
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   // drain side
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:D-1];
   reg [AW:0]  wp_r;
   reg [AW:0]  rp_r;
   wire        full;
   wire        empty;

   // extra pointer bit tells full from empty
   assign empty     = (wp_r == rp_r);
   assign full      = (wp_r[AW] != rp_r[AW]) &&
                      (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rp_r[AW-1:0]];

   // storage has no reset, only pointers matter
   always @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end

   // pointer update
   always @(posedge clk) begin
      if (srst) begin
         wp_r <= {(AW+1){1'b0}};
         rp_r <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            wp_r <= wp_r + 1'b1;
         end
         if (out_ready && !empty) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule

module stx_top (
   // clock and reset
   input  wire        CLK,
   input  wire        SRST,
   // configuration
   input  wire        TX_ON,
   input  wire [2:0]  CHAR_SIZE,
   input  wire [1:0]  PARITY_MODE,
   input  wire        STOP_BITS_SEL,
   input  wire        DOUBLE_SPEED,
   input  wire        SYNC_MODE,
   input  wire        SYNC_MASTER,
   input  wire [11:0] BAUD_DIV,
   input  wire        TX_NINTH_BIT,
   // data buffer write
   input  wire        DATA_WR,
   input  wire [7:0]  DATA_IN,
   output wire        DATA_READY,
   // flags and interrupt control
   output wire        TX_BUF_EMPTY,
   output wire        TX_COMPLETE,
   input  wire        TXC_CLEAR,
   input  wire        TXC_ACK,
   input  wire        BUF_EMPTY_IRQ_EN,
   input  wire        TXC_IRQ_EN,
   input  wire        GLOBAL_IRQ_EN,
   output wire        BUF_EMPTY_IRQ,
   output wire        TXC_IRQ,
   // serial output pin and ordinary port drive
   input  wire        PORT_DOUT,
   input  wire        PORT_OE,
   output wire        SERIAL_OUT,
   output wire        SERIAL_OUT_OE,
   // sync clock pin
   input  wire        SYNC_CLK_IN,
   output wire        SYNC_CLK_OUT,
   output wire        SYNC_CLK_OE
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_START = 3'h1;
   localparam ST_DATA  = 3'h2;
   localparam ST_PAR   = 3'h3;
   localparam ST_STOP  = 3'h4;

   // number of data bits for a size code
   function [3:0] nbits;
      input [2:0] code;
      begin
         if (code == `STX_SIZE_NINE) begin
            nbits = 4'h9;
         end else begin
            nbits = {2'b01, code[1:0]} + 4'h1;
         end
      end
   endfunction

   // keep only the low n bits of a character
   function [8:0] lowmask;
      input [8:0] d;
      input [3:0] n;
      integer i;
      begin
         lowmask = 9'h000;
         for (i = 0; i < 9; i = i + 1) begin
            if (i < n) begin
               lowmask[i] = d[i];
            end
         end
      end
   endfunction

   reg  [2:0]  st_r;
   reg  [8:0]  sh_r;
   reg  [3:0]  cnt_r;
   reg         par_r;
   reg         line_r;
   reg         txc_r;
   reg         en_r;
   reg  [11:0] baud_r;
   reg  [3:0]  pre_r;
   reg         xck_r;
   reg         xin_r;
   wire        baud_tick;
   wire        bit_en;
   wire        f_valid;
   wire        f_pop;
   wire [8:0]  f_data;
   wire [3:0]  n_bits;
   wire [8:0]  chr;
   wire        last_stop;
   wire        load;
   wire [3:0]  div;

   assign n_bits = nbits(CHAR_SIZE);

   // transmit buffer; its ready stalls the writer when full
   stx_fifo #(
      .W  (`STX_FIFO_W),
      .D  (`STX_FIFO_DEPTH),
      .AW (`STX_FIFO_AW)
   ) u_buf (
      .clk       (CLK),
      .srst      (SRST),
      .in_valid  (DATA_WR),
      .in_ready  (DATA_READY),
      .in_data   ({TX_NINTH_BIT, DATA_IN}),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   // baud generator: down-counter, tick at zero then reload
   assign baud_tick = (baud_r == 12'h000);
   always @(posedge CLK) begin
      if (SRST) begin
         baud_r <= `STX_BAUD_RST;
      end else if (baud_tick) begin
         baud_r <= BAUD_DIV;
      end else begin
         baud_r <= baud_r - 12'h001;
      end
   end

   // divide select; master sync uses the xck toggle below
   assign div = SYNC_MODE    ? `STX_DIV_SYNC :
                DOUBLE_SPEED ? `STX_DIV_DBL  : `STX_DIV_NORM;

   // prescaler and sync clock pin handling
   always @(posedge CLK) begin
      if (SRST) begin
         pre_r <= 4'h0;
         xck_r <= 1'b0;
         xin_r <= SYNC_CLK_IN;   // no false pin edge out of reset
      end else begin
         xin_r <= SYNC_CLK_IN;
         if (baud_tick) begin
            pre_r <= (pre_r >= div) ? 4'h0 : pre_r + 4'h1;
            xck_r <= ~xck_r;
         end
      end
   end

   // bit enable: slave uses rising pin edge, data changes there
   assign bit_en = !SYNC_MODE  ? (baud_tick && pre_r >= div) :
                   SYNC_MASTER ? (baud_tick && !xck_r) :
                                 (SYNC_CLK_IN && !xin_r);

   assign SYNC_CLK_OUT = xck_r;
   assign SYNC_CLK_OE  = SYNC_MODE && SYNC_MASTER;

   // frame end and buffer hand-off
   assign last_stop = (st_r == ST_STOP) && bit_en &&
                      (cnt_r == {3'h0, STOP_BITS_SEL});
   assign load  = en_r && f_valid && bit_en &&
                  ((st_r == ST_IDLE) || last_stop);
   assign f_pop = load;
   assign chr   = lowmask(f_data, n_bits);

   // frame shifter; line changes only on bit enables
   always @(posedge CLK) begin
      if (SRST) begin
         st_r   <= ST_IDLE;
         sh_r   <= 9'h000;
         cnt_r  <= 4'h0;
         par_r  <= 1'b0;
         line_r <= `STX_LINE_IDLE;
      end else if (load) begin
         st_r   <= ST_START;
         sh_r   <= chr;
         cnt_r  <= 4'h0;
         par_r  <= (^chr) ^ PARITY_MODE[`STX_PAR_ODD_BIT];
         line_r <= 1'b0;
      end else if (bit_en) begin
         case (st_r)
            ST_IDLE: begin
               line_r <= `STX_LINE_IDLE;
            end
            ST_START, ST_DATA: begin
               if (st_r == ST_DATA && cnt_r == n_bits) begin
                  cnt_r <= 4'h0;
                  if (PARITY_MODE[`STX_PAR_EN_BIT]) begin
                     st_r   <= ST_PAR;
                     line_r <= par_r;
                  end else begin
                     st_r   <= ST_STOP;
                     line_r <= 1'b1;
                  end
               end else begin
                  st_r   <= ST_DATA;
                  line_r <= sh_r[0];
                  sh_r   <= {1'b0, sh_r[8:1]};
                  cnt_r  <= cnt_r + 4'h1;
               end
            end
            ST_PAR: begin
               st_r   <= ST_STOP;
               line_r <= 1'b1;
            end
            ST_STOP: begin
               if (last_stop) begin
                  st_r <= ST_IDLE;
               end else begin
                  cnt_r  <= cnt_r + 4'h1;
                  line_r <= 1'b1;
               end
            end
            default: begin
               st_r   <= ST_IDLE;
               line_r <= `STX_LINE_IDLE;
            end
         endcase
      end
   end

   // complete flag; a frame end in the clear cycle still sets it
   always @(posedge CLK) begin
      if (SRST) begin
         txc_r <= 1'b0;
      end else if (last_stop && !f_valid) begin
         txc_r <= 1'b1;
      end else if (TXC_CLEAR || TXC_ACK) begin
         txc_r <= 1'b0;
      end
   end

   // enable holds until shifter and buffer have drained
   always @(posedge CLK) begin
      if (SRST) begin
         en_r <= 1'b0;
      end else if (TX_ON) begin
         en_r <= 1'b1;
      end else if (st_r == ST_IDLE && !f_valid) begin
         en_r <= 1'b0;
      end
   end

   // pin ownership: ordinary port logic when disabled
   assign SERIAL_OUT    = en_r ? line_r : PORT_DOUT;
   assign SERIAL_OUT_OE = en_r ? 1'b1 : PORT_OE;

   // flags and requests; empty drops on the write edge
   assign TX_BUF_EMPTY  = !f_valid;
   assign TX_COMPLETE   = txc_r;
   assign BUF_EMPTY_IRQ = GLOBAL_IRQ_EN && BUF_EMPTY_IRQ_EN &&
                          !f_valid;
   assign TXC_IRQ       = GLOBAL_IRQ_EN && TXC_IRQ_EN &&
                          txc_r;
endmodule

// [test/stx_assertions.sv]
/*
 checker for the serial transmitter: flags, requests, pin takeover.
 assumes it is bound to stx_top and sees only its ports.
*/
`timescale 1ns/1ns
module stx_chk (
   // clock and reset
   input wire CLK,
   input wire SRST,
   // configuration and writes
   input wire TX_ON,
   input wire DOUBLE_SPEED,
   input wire SYNC_MODE,
   input wire SYNC_MASTER,
   input wire DATA_WR,
   input wire DATA_READY,
   // flags and requests
   input wire TX_BUF_EMPTY,
   input wire TX_COMPLETE,
   input wire TXC_CLEAR,
   input wire TXC_ACK,
   input wire BUF_EMPTY_IRQ_EN,
   input wire TXC_IRQ_EN,
   input wire GLOBAL_IRQ_EN,
   input wire BUF_EMPTY_IRQ,
   input wire TXC_IRQ,
   // pins
   input wire SERIAL_OUT,
   input wire SERIAL_OUT_OE,
   input wire SYNC_CLK_OE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   // a low bit in normal mode lasts far longer than eight clocks
   sequence s_low_run;
      !SERIAL_OUT [*8];
   endsequence

   a_bufirq_level: assert property (BUF_EMPTY_IRQ == (GLOBAL_IRQ_EN &&
      BUF_EMPTY_IRQ_EN && TX_BUF_EMPTY)) else $error("buffer request bad");
   a_txcirq_level: assert property (TXC_IRQ == (GLOBAL_IRQ_EN &&
      TXC_IRQ_EN && TX_COMPLETE)) else $error("complete request bad");
   a_wr_clears_empty: assert property (DATA_WR && DATA_READY
      |=> !TX_BUF_EMPTY) else $error("write left buffer empty");
   a_full_not_empty: assert property (!DATA_READY
      |-> !TX_BUF_EMPTY) else $error("full buffer shown empty");
   a_txc_clears: assert property ((TXC_ACK || TXC_CLEAR) && TX_COMPLETE
      |=> !TX_COMPLETE) else $error("complete flag not cleared");
   a_txc_sets_idle: assert property ($rose(TX_COMPLETE)
      |-> $past(TX_BUF_EMPTY) && $past(SERIAL_OUT))
      else $error("early complete");
   a_pin_taken: assert property (TX_ON && $past(TX_ON) && !$past(SRST)
      |-> SERIAL_OUT_OE) else $error("pin not driven while on");
   a_low_bit_holds: assert property (TX_ON && $past(TX_ON) &&
      SERIAL_OUT_OE && !SYNC_MODE && !DOUBLE_SPEED && $fell(SERIAL_OUT)
      |-> s_low_run) else $error("low bit too short");
   a_sync_clk_oe: assert property (SYNC_CLK_OE == (SYNC_MODE &&
      SYNC_MASTER)) else $error("sync clock drive bad");
endmodule

bind stx_top stx_chk u_chk (
   .CLK(CLK), .SRST(SRST), .TX_ON(TX_ON), .DOUBLE_SPEED(DOUBLE_SPEED),
   .SYNC_MODE(SYNC_MODE), .SYNC_MASTER(SYNC_MASTER), .DATA_WR(DATA_WR),
   .DATA_READY(DATA_READY), .TX_BUF_EMPTY(TX_BUF_EMPTY),
   .TX_COMPLETE(TX_COMPLETE), .TXC_CLEAR(TXC_CLEAR), .TXC_ACK(TXC_ACK),
   .BUF_EMPTY_IRQ_EN(BUF_EMPTY_IRQ_EN), .TXC_IRQ_EN(TXC_IRQ_EN),
   .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .BUF_EMPTY_IRQ(BUF_EMPTY_IRQ),
   .TXC_IRQ(TXC_IRQ), .SERIAL_OUT(SERIAL_OUT),
   .SERIAL_OUT_OE(SERIAL_OUT_OE), .SYNC_CLK_OE(SYNC_CLK_OE)
);

// [test/stx_rx_model.sv]
/*
 remote receiver model: listens on the serial line, samples mid bit.
 assumes the line idles high and the bit length in clocks is given.
*/
`timescale 1ns/1ns
module stx_rx_model (
   input  wire       clk,
   input  wire       line,
   input  wire [4:0] bit_clks,
   input  wire [3:0] nbits,
   input  wire       par_en,
   output reg  [8:0] rx_data,
   output reg        rx_par,
   output reg        rx_stop,
   output reg  [7:0] rx_count
);
   integer i;
   // passive listener, so it never disturbs the line
   initial begin
      rx_data  = 9'h000;
      rx_par   = 1'b0;
      rx_stop  = 1'b0;
      rx_count = 8'h00;
      forever begin
         @(negedge line);
         // a short frame must not inherit high bits of a longer one
         rx_data = 9'h000;
         repeat (bit_clks / 2) @(posedge clk);
         for (i = 0; i < nbits; i = i + 1) begin
            repeat (bit_clks) @(posedge clk);
            rx_data[i] = line;
         end
         if (par_en) begin
            repeat (bit_clks) @(posedge clk);
            rx_par = line;
         end
         repeat (bit_clks) @(posedge clk);
         rx_stop  = line;
         rx_count = rx_count + 8'h01;
      end
   end
endmodule

// [test/stx_top_tb.sv]
/*
 testbench for the serial transmitter: formats, flags, full buffer.
 assumes the rx model decodes the line; port pin idles high.
*/
`timescale 1ns/1ns
module stx_top_tb;
   reg         CLK = 1'b0, SRST = 1'b1, TX_ON = 1'b0, STOP_BITS_SEL = 1'b0;
   reg  [2:0]  CHAR_SIZE = 3'h3;
   reg  [1:0]  PARITY_MODE = 2'h0;
   reg         DOUBLE_SPEED = 1'b0, SYNC_MODE = 1'b0, SYNC_MASTER = 1'b0;
   reg         TX_NINTH_BIT = 1'b0, DATA_WR = 1'b0, TXC_CLEAR = 1'b0;
   reg         TXC_ACK = 1'b0, GLOBAL_IRQ_EN = 1'b1;
   reg         BUF_EMPTY_IRQ_EN = 1'b1, SYNC_CLK_IN = 1'b0;
   reg  [7:0]  DATA_IN = 8'h00;
   wire        DATA_READY, TX_BUF_EMPTY, TX_COMPLETE, BUF_EMPTY_IRQ, TXC_IRQ;
   wire        SERIAL_OUT, SERIAL_OUT_OE;
   wire [8:0]  rx_data;
   wire [7:0]  rx_count;
   wire        rx_par, rx_stop;
   reg  [3:0]  nbits = 4'h8;
   reg  [8:0]  mask;
   reg  [7:0]  n0;
   integer     err_count = 0, cmp_count = 0, i, k, waited;
   logic [2:0] cs_t [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   logic [1:0] pm_t [5] = '{2'h2, 2'h3, 2'h0, 2'h3, 2'h2};
   logic [8:0] d_t [5] = '{9'h0ff, 9'h0aa, 9'h17e, 9'h0c3, 9'h1a5};
   wire  [4:0] bclk = SYNC_MODE ? 5'h02 : (DOUBLE_SPEED ? 5'h08 : 5'h10);

   always #5 CLK = ~CLK;

   // slave sync clock: toggles each cycle in slave mode, else held low
   always @(posedge CLK) #1
      SYNC_CLK_IN = SYNC_MODE && !SYNC_MASTER && !SYNC_CLK_IN;

   stx_top dut (.CLK(CLK), .SRST(SRST), .TX_ON(TX_ON), .CHAR_SIZE(CHAR_SIZE),
      .PARITY_MODE(PARITY_MODE), .STOP_BITS_SEL(STOP_BITS_SEL),
      .DOUBLE_SPEED(DOUBLE_SPEED), .SYNC_MODE(SYNC_MODE),
      .SYNC_MASTER(SYNC_MASTER), .BAUD_DIV(12'h000),
      .TX_NINTH_BIT(TX_NINTH_BIT), .DATA_WR(DATA_WR), .DATA_IN(DATA_IN),
      .DATA_READY(DATA_READY), .TX_BUF_EMPTY(TX_BUF_EMPTY),
      .TX_COMPLETE(TX_COMPLETE), .TXC_CLEAR(TXC_CLEAR), .TXC_ACK(TXC_ACK),
      .BUF_EMPTY_IRQ_EN(BUF_EMPTY_IRQ_EN), .TXC_IRQ_EN(1'b1),
      .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .BUF_EMPTY_IRQ(BUF_EMPTY_IRQ),
      .TXC_IRQ(TXC_IRQ), .PORT_DOUT(1'b1), .PORT_OE(1'b0),
      .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE),
      .SYNC_CLK_IN(SYNC_CLK_IN), .SYNC_CLK_OUT(), .SYNC_CLK_OE());

   stx_rx_model rx (.clk(CLK), .line(SERIAL_OUT), .bit_clks(bclk),
      .nbits(nbits), .par_en(PARITY_MODE[1]), .rx_data(rx_data),
      .rx_par(rx_par), .rx_stop(rx_stop), .rx_count(rx_count));

   task report_and_stop;
      begin
         if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask

   // all tasks start and end just after a rising edge
   task wr(input logic [8:0] d);
      begin
         DATA_WR      = 1'b1;
         DATA_IN      = d[7:0];
         TX_NINTH_BIT = d[8]; // ninth bit rides with the low byte
         @(posedge CLK) #1;
         DATA_WR      = 1'b0;
         @(posedge CLK) #1; // idle edge before the strobe may rise again
      end
   endtask

   task pulse(input logic ack);
      begin
         TXC_ACK   = ack;
         TXC_CLEAR = !ack; // complete flag position written one
         @(posedge CLK) #1;
         TXC_ACK   = 1'b0;
         TXC_CLEAR = 1'b0;
         @(posedge CLK) #1; // idle edge before the next clear
      end
   endtask

   // bounded wait for the receiver to finish frame number n
   task wait_rx(input [7:0] n);
      begin
         for (waited = 0; waited < 400 && rx_count != n; waited++)
            @(posedge CLK) #1;
         if (rx_count != n) begin
            chk("rx_count", rx_count, n);
            report_and_stop;
         end
      end
   endtask

   // bounded wait for the complete flag; a timeout ends the run
   task wait_txc;
      begin
         for (k = 0; k < 60 && TX_COMPLETE !== 1'b1; k++)
            @(posedge CLK) #1;
         chk("complete", TX_COMPLETE, 9'h001);
         if (TX_COMPLETE !== 1'b1)
            report_and_stop;
      end
   endtask

   initial begin
      repeat (3) @(posedge CLK);
      #1 SRST = 1'b0;
      chk("buf_empty", TX_BUF_EMPTY, 9'h001);
      chk("complete", TX_COMPLETE, 9'h000);
      chk("pin_oe", SERIAL_OUT_OE, 9'h000);
      // size codes 0 to 3 and 7, each parity kind; config precedes writes
      for (i = 0; i < 5; i++) begin
         CHAR_SIZE     = cs_t[i]; // only between frames
         PARITY_MODE   = pm_t[i];
         STOP_BITS_SEL = i[0];
         DOUBLE_SPEED  = (i == 3);
         nbits = (cs_t[i] == 3'h7) ? 4'h9 : {1'b0, cs_t[i]} + 4'h5;
         mask  = (9'h001 << nbits) - 9'h001;
         TX_ON = 1'b1;
         pulse(1'b0); // flag cleared before each character
         n0 = rx_count;
         wr(d_t[i]);
         wait_rx(n0 + 8'h01);
         chk("rx_data", rx_data, d_t[i] & mask);
         if (pm_t[i][1])
            chk("rx_par", rx_par, ^(d_t[i] & mask) ^ pm_t[i][0]);
         chk("rx_stop", rx_stop, 9'h001);
         wait_txc;
         chk("txc_irq", TXC_IRQ, 9'h001);
         pulse(i[0]);
         chk("complete", TX_COMPLETE, 9'h000);
      end
      // fill while off, ninth write refused, then drain while turning off
      TX_ON = 1'b0;
      CHAR_SIZE = 3'h3;
      PARITY_MODE = 2'h0;
      STOP_BITS_SEL = 1'b0;
      DOUBLE_SPEED = 1'b0;
      nbits = 4'h8;
      for (i = 0; i < 9; i++)
         wr(9'h030 + i);
      chk("data_ready", DATA_READY, 9'h000);
      chk("buf_irq", BUF_EMPTY_IRQ, 9'h000);
      n0 = rx_count;
      TX_ON = 1'b1;
      for (i = 0; i < 8; i++) begin
         wait_rx(n0 + i + 1);
         TX_ON = 1'b0;
         chk("rx_data", rx_data, 9'h030 + i);
         if (i > 0)
            chk("gap", waited, 9'h0a0);
      end
      repeat (300) @(posedge CLK);
      #1 chk("rx_count", rx_count, n0 + 8'h08);
      chk("buf_irq", BUF_EMPTY_IRQ, 9'h001);
      chk("pin_oe", SERIAL_OUT_OE, 9'h000);
      GLOBAL_IRQ_EN = 1'b0;
      #1 chk("buf_irq", BUF_EMPTY_IRQ, 9'h000);
      @(posedge CLK) #1;
      GLOBAL_IRQ_EN = 1'b1;
      BUF_EMPTY_IRQ_EN = 1'b0;
      #1 chk("buf_irq", BUF_EMPTY_IRQ, 9'h000);
      @(posedge CLK) #1;
      // synchronous master then slave, two clocks per bit
      SYNC_MODE = 1'b1;
      TX_ON = 1'b1;
      for (i = 0; i < 2; i++) begin
         SYNC_MASTER = !i[0]; // only between frames
         pulse(1'b0);
         n0 = rx_count;
         wr(9'h055 + i);
         wait_rx(n0 + 8'h01);
         chk("rx_data", rx_data, 9'h055 + i);
         wait_txc;
      end
      report_and_stop;
   end
endmodule
